//--- verilog/cds_decoder.sv
// code and data space decoder with an axi4-lite configuration slave
//
// How it works
// - address space splits into lower 16K, middle 16K and upper 32K areas
// - code fetches at 2000h-3fffh always enable the eprom, never the ram
// - data reads and writes in the lower area always enable the ram
// - code fetches at 0000h-1fffh are internal; no socket is enabled
// - middle area code fetches go to ram or eprom by a routing bit
// - middle area data reads go to ram or eprom by a separate bit
// - upper area code fetches and data reads each have their own routing bit
// - after reset reads go to ram and code fetches to eprom
// - smaller eproms alias: upper address lines beyond their size are dropped
// - three size bits gate eprom lines a13, a14, a15 for four sizes
// - ram sizes 8K to 128K; smaller parts alias across address blocks
//
// Local design decisions: register access over AXI4-Lite and the register addresses.
`timescale 1ns/10ps
`include "cds_cfg.svh"
module cds_decoder
    import cds_pkg::*;
#(
    parameter int AW = 8
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire cds_bus_s cpu_bus,
    output cds_mem_ctl_s mem_ctl,
    output logic [3:0] ram_addr_hi,
    output logic [2:0] eprom_addr_hi,
    output logic internal_code_select
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------

    // socket for one access; a is a15..a13, writes win over reads over fetches
    function automatic cds_target_e decode_target(
        input logic [2:0] a,
        input logic code,
        input logic rd,
        input logic wr,
        input cds_route_s rt
    );
        cds_target_e t;
        t = CDS_TGT_NONE;
        if (wr) begin
            t = CDS_TGT_RAM;
        end else if (rd) begin
            if (a[2:1] == `CDS_REGION_LOWER) begin
                t = CDS_TGT_RAM;
            end else if (a[2:1] == `CDS_REGION_MID) begin
                t = rt.mid_rd_eprom ? CDS_TGT_EPROM : CDS_TGT_RAM;
            end else begin
                t = rt.up_rd_eprom ? CDS_TGT_EPROM : CDS_TGT_RAM;
            end
        end else if (code) begin
            if (a[2:1] == `CDS_REGION_LOWER) begin
                t = a[0] ? CDS_TGT_EPROM : CDS_TGT_NONE;
            end else if (a[2:1] == `CDS_REGION_MID) begin
                t = rt.mid_code_ram ? CDS_TGT_RAM : CDS_TGT_EPROM;
            end else begin
                t = rt.up_code_ram ? CDS_TGT_RAM : CDS_TGT_EPROM;
            end
        end
        return t;
    endfunction

    // ram upper lines a16..a13 by installed size
    function automatic logic [3:0] ram_lines(
        input logic [2:0] a,
        input logic [1:0] size,
        input logic page
    );
        logic [3:0] l;
        l = 4'h0;
        case (size)
            `CDS_RAM_8K: l = 4'h0;
            `CDS_RAM_32K: l = {2'b00, a[1:0]};
            default: l = {page, a};
        endcase
        return l;
    endfunction

    // register offset is one of the four words
    function automatic logic addr_ok(input logic [AW-1:0] addr);
        logic ok;
        ok = (addr[7:0] == `CDS_OFF_ROUTE) || (addr[7:0] == `CDS_OFF_EPROM) ||
             (addr[7:0] == `CDS_OFF_RAM) || (addr[7:0] == `CDS_OFF_STATUS);
        if (AW > 8) begin
            ok = ok && ((addr >> 8) == '0);
        end
        return ok;
    endfunction

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    cds_bus_s s_bus;
    cds_route_s route;
    logic [2:0] eprom_size;
    logic [1:0] ram_size;
    logic ram_page;
    cds_target_e last_target;
    logic last_code;
    logic stray_fetch;
    logic aw_held;
    logic w_held;
    logic [AW-1:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic commit;
    logic stray_clr;
    cds_target_e next_target;
    logic any_strobe;
    logic code_act;
    logic rd_act;
    logic wr_act;

    // ----------------------------------------------------------------
    // pin synchronisation
    // ----------------------------------------------------------------
    cds_sync #(
        .W($bits(cds_bus_s)),
        .RST_VAL({3'b111, 8'h00})
    ) u_sync (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .din(cpu_bus),
        .dout(s_bus)
    );

    // ----------------------------------------------------------------
    // access decode
    // ----------------------------------------------------------------

    // active-high strobes and chosen socket
    always_comb begin
        code_act = !s_bus.code_fetch_strobe_n;
        rd_act = !s_bus.rd_n;
        wr_act = !s_bus.wr_n;
        any_strobe = code_act || rd_act || wr_act;
        next_target = decode_target(s_bus.addr_hi[7:5], code_act, rd_act, wr_act, route);
    end

    // socket enables, registered
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            mem_ctl <= '1;
        end else begin
            mem_ctl.ram_ce_n <= !(next_target == CDS_TGT_RAM);
            mem_ctl.ram_oe_n <= !(next_target == CDS_TGT_RAM && !wr_act);
            mem_ctl.ram_we_n <= !(next_target == CDS_TGT_RAM && wr_act);
            mem_ctl.eprom_ce_n <= !(next_target == CDS_TGT_EPROM);
            mem_ctl.eprom_oe_n <= !(next_target == CDS_TGT_EPROM);
        end
    end

    // upper address lines to both sockets
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            eprom_addr_hi <= 3'h0;
            ram_addr_hi <= 4'h0;
        end else begin
            eprom_addr_hi <= s_bus.addr_hi[7:5] & eprom_size;
            ram_addr_hi <= ram_lines(s_bus.addr_hi[7:5], ram_size, ram_page);
        end
    end

    // strap to the processor: run the internal interpreter
    always_ff @(posedge clk_sys) begin
        internal_code_select <= 1'b1;
    end

    // last access seen, for software
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            last_target <= CDS_TGT_NONE;
            last_code <= 1'b0;
        end else if (any_strobe) begin
            last_target <= next_target;
            last_code <= code_act && !rd_act && !wr_act;
        end
    end

    // sticky fetch in the internal area; a new hit beats the clear
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stray_fetch <= 1'b0;
        end else if (code_act && !rd_act && !wr_act && s_bus.addr_hi[7:5] == 3'b000) begin
            stray_fetch <= 1'b1;
        end else if (stray_clr) begin
            stray_fetch <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write path
    // ----------------------------------------------------------------

    // address and data latch independently, response after both
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            aw_held <= 1'b0;
            aw_addr_q <= '0;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held <= 1'b0;
        end else if (!aw_held) begin
            s_axi_awready <= 1'b1;
        end
    end

    // write data latch
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            w_held <= 1'b0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held <= 1'b0;
        end else if (!w_held) begin
            s_axi_wready <= 1'b1;
        end
    end

    // one commit per write, while the response is not yet out
    always_comb begin
        commit = aw_held && w_held && !s_axi_bvalid;
        stray_clr = commit && aw_addr_q[7:0] == `CDS_OFF_STATUS && addr_ok(aw_addr_q) &&
                    w_strb_q[1] && w_data_q[`CDS_STAT_STRAY_BIT];
    end

    // write response
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `CDS_RESP_OKAY;
        end else if (commit) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= addr_ok(aw_addr_q) ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // configuration registers, low byte lane only
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            route <= cds_route_s'(`CDS_RST_ROUTE);
            eprom_size <= `CDS_RST_EPROM;
            ram_size <= `CDS_RST_RAM_SIZE;
            ram_page <= `CDS_RST_RAM_PAGE;
        end else if (commit && w_strb_q[0] && addr_ok(aw_addr_q)) begin
            case (aw_addr_q[7:0])
                `CDS_OFF_ROUTE: route <= cds_route_s'(w_data_q[3:0]);
                `CDS_OFF_EPROM: eprom_size <= w_data_q[2:0];
                `CDS_OFF_RAM: begin
                    ram_size <= w_data_q[1:0];
                    ram_page <= w_data_q[`CDS_RAM_PAGE_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read path
    // ----------------------------------------------------------------

    // one read at a time, data one cycle after the address
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `CDS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= addr_ok(s_axi_araddr) ? `CDS_RESP_OKAY : `CDS_RESP_SLVERR;
            s_axi_rdata <= 32'h0000_0000;
            if (addr_ok(s_axi_araddr)) begin
                case (s_axi_araddr[7:0])
                    `CDS_OFF_ROUTE: s_axi_rdata[3:0] <= route;
                    `CDS_OFF_EPROM: s_axi_rdata[2:0] <= eprom_size;
                    `CDS_OFF_RAM: begin
                        s_axi_rdata[1:0] <= ram_size;
                        s_axi_rdata[`CDS_RAM_PAGE_BIT] <= ram_page;
                    end
                    default: begin
                        s_axi_rdata[2:0] <= last_target;
                        s_axi_rdata[`CDS_STAT_CODE_BIT] <= last_code;
                        s_axi_rdata[`CDS_STAT_STRAY_BIT] <= stray_fetch;
                    end
                endcase
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------

    AST_LOWER_DATA_RAM: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        ((rd_act || wr_act) && s_bus.addr_hi[7:6] == 2'b00)
        |=> (!mem_ctl.ram_ce_n && mem_ctl.eprom_ce_n))
        else $error("lower area data access did not pick ram");

    AST_LOWER_CODE_EPROM: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (code_act && !rd_act && !wr_act && s_bus.addr_hi[7:5] == 3'b001)
        |=> (!mem_ctl.eprom_ce_n && !mem_ctl.eprom_oe_n && mem_ctl.ram_ce_n))
        else $error("lower area code fetch did not pick eprom");

    AST_INTERNAL_FETCH: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (code_act && !rd_act && !wr_act && s_bus.addr_hi[7:5] == 3'b000)
        |=> (mem_ctl.ram_ce_n && mem_ctl.eprom_ce_n && stray_fetch))
        else $error("internal area fetch enabled a socket");

    AST_MID_CODE: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (code_act && !rd_act && !wr_act && s_bus.addr_hi[7:6] == 2'b01)
        |=> (mem_ctl.ram_ce_n == !$past(route.mid_code_ram)) && (mem_ctl.eprom_ce_n != mem_ctl.ram_ce_n))
        else $error("middle area code fetch misrouted");

    AST_MID_READ: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (rd_act && !wr_act && s_bus.addr_hi[7:6] == 2'b01)
        |=> (mem_ctl.eprom_ce_n == !$past(route.mid_rd_eprom)) && (mem_ctl.eprom_ce_n != mem_ctl.ram_ce_n))
        else $error("middle area data read misrouted");

    AST_UPPER_ROUTE: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (!wr_act && (rd_act || code_act) && s_bus.addr_hi[7])
        |=> (mem_ctl.eprom_ce_n == ($past(rd_act) ? !$past(route.up_rd_eprom) : $past(route.up_code_ram))))
        else $error("upper area access misrouted");

    AST_RESET_DEFAULT: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $fell(sys_rst) |-> (route == cds_route_s'(`CDS_RST_ROUTE) && eprom_size == `CDS_RST_EPROM))
        else $error("routing not at default after reset");

    AST_EPROM_ALIAS: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (!mem_ctl.eprom_ce_n) |-> (eprom_addr_hi == ($past(s_bus.addr_hi[7:5]) & $past(eprom_size))))
        else $error("eprom upper lines not masked by size");

    AST_EPROM_8K: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (eprom_size == 3'h0) |=> (eprom_addr_hi == 3'h0))
        else $error("8K eprom saw an upper address line");

    AST_RAM_ALIAS: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        (ram_size == `CDS_RAM_32K) |=> (ram_addr_hi[3:2] == 2'b00 && ram_addr_hi[1:0] == $past(s_bus.addr_hi[6:5])))
        else $error("32K ram upper lines wrong");

    AST_WRITE_RAM_ONLY: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        wr_act |=> (!mem_ctl.ram_we_n && mem_ctl.ram_oe_n && mem_ctl.eprom_ce_n && mem_ctl.eprom_oe_n))
        else $error("write reached the eprom");

    AST_STRAP_HIGH: assert property (
        @(posedge clk_sys) disable iff (sys_rst)
        $past(sys_rst) |=> internal_code_select)
        else $error("internal code select not high");

endmodule

//--- pkg/cds_cfg.svh
// register offsets, field positions, reset values and codes for the space decoder
`ifndef CDS_CFG_SVH
`define CDS_CFG_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define CDS_OFF_ROUTE 8'h00
`define CDS_OFF_EPROM 8'h04
`define CDS_OFF_RAM 8'h08
`define CDS_OFF_STATUS 8'h0c

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CDS_RST_ROUTE 4'h0
`define CDS_RST_EPROM 3'h7
`define CDS_RST_RAM_SIZE 2'h2
`define CDS_RST_RAM_PAGE 1'b0

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CDS_RAM_PAGE_BIT 4
`define CDS_STAT_CODE_BIT 4
`define CDS_STAT_STRAY_BIT 8

// ----------------------------------------------------------------
// codes
// ----------------------------------------------------------------
`define CDS_RAM_8K 2'h0
`define CDS_RAM_32K 2'h1
`define CDS_RAM_128K 2'h2
`define CDS_REGION_LOWER 2'h0
`define CDS_REGION_MID 2'h1
`define CDS_RESP_OKAY 2'h0
`define CDS_RESP_SLVERR 2'h2

`endif

//--- pkg/cds_pkg.sv
// types shared by the code and data space decoder
package cds_pkg;

    // ----------------------------------------------------------------
    // socket selected by one access
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        CDS_TGT_NONE = 3'b001,
        CDS_TGT_RAM = 3'b010,
        CDS_TGT_EPROM = 3'b100
    } cds_target_e;

    // ----------------------------------------------------------------
    // routing selections of the two upper areas
    // ----------------------------------------------------------------
    typedef struct packed {
        logic up_rd_eprom;
        logic up_code_ram;
        logic mid_rd_eprom;
        logic mid_code_ram;
    } cds_route_s;

    // processor bus strobes and high address byte
    typedef struct packed {
        logic code_fetch_strobe_n;
        logic rd_n;
        logic wr_n;
        logic [7:0] addr_hi;
    } cds_bus_s;

    // socket enables, all active low
    typedef struct packed {
        logic ram_ce_n;
        logic ram_oe_n;
        logic ram_we_n;
        logic eprom_ce_n;
        logic eprom_oe_n;
    } cds_mem_ctl_s;

endpackage

//--- verilog/cds_sync.sv
// two flip-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module cds_sync #(
    parameter int W = 11,
    parameter logic [W-1:0] RST_VAL = '1
) (
    input wire logic clk_sys,
    input wire logic sys_rst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta;

    // first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            meta <= RST_VAL;
            dout <= RST_VAL;
        end else begin
            meta <= din;
            dout <= meta;
        end
    end
endmodule

//--- dv/cds_cpu_model.sv
// processor external bus model: strobes and high address byte
`timescale 1ns/10ps
module cds_cpu_model
    import cds_pkg::*;
(
    input wire logic clk_sys,
    input wire logic internal_code_select,
    output cds_bus_s cpu_bus
);
    // ----------------------------------------------------------------
    // idle bus
    // ----------------------------------------------------------------
    initial begin
        cpu_bus = '{code_fetch_strobe_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, addr_hi: 8'h00};
    end

    // one strobe at a time: 0 fetch, 1 read, 2 write
    task automatic start(input int kind, input logic [7:0] a);
        while (internal_code_select !== 1'b1) begin
            @(posedge clk_sys);
        end
        @(posedge clk_sys);
        cpu_bus.addr_hi <= a;
        cpu_bus.code_fetch_strobe_n <= (kind != 0);
        cpu_bus.rd_n <= (kind != 1);
        cpu_bus.wr_n <= (kind != 2);
    endtask

    // release: strobes high, stale address no longer shown
    task automatic stop();
        @(posedge clk_sys);
        cpu_bus.code_fetch_strobe_n <= 1'b1;
        cpu_bus.rd_n <= 1'b1;
        cpu_bus.wr_n <= 1'b1;
        cpu_bus.addr_hi <= ~cpu_bus.addr_hi;
    endtask
endmodule

//--- dv/tb_code_data_space_decoder.sv
// self-checking bench for the code and data space decoder
`timescale 1ns/10ps
`include "cds_cfg.svh"
module tb_code_data_space_decoder
    import cds_pkg::*;
;
    logic clk_sys = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    // responses are always accepted, so bready and rready stay high
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b1, arvalid = 1'b0, rready = 1'b1;
    logic [31:0] wdata = 32'h0, rdata;
    logic awready, wready, bvalid, arready, rvalid, ics;
    logic [1:0] bresp, rresp;
    cds_bus_s cpu_bus;
    cds_mem_ctl_s mem_ctl;
    logic [3:0] ram_addr_hi;
    logic [2:0] eprom_addr_hi;
    int err_count = 0, samples_checked = 0, cycles = 0;

    always #2.5 clk_sys = ~clk_sys;

    cds_decoder #(.AW(8)) DUT (.clk_sys(clk_sys), .sys_rst(sys_rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .cpu_bus(cpu_bus),
        .mem_ctl(mem_ctl), .ram_addr_hi(ram_addr_hi), .eprom_addr_hi(eprom_addr_hi),
        .internal_code_select(ics));
    cds_cpu_model cpu (.clk_sys(clk_sys), .internal_code_select(ics), .cpu_bus(cpu_bus));

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 40000) begin
            err_count++;
            summarize();
        end
    end

    // requests raised after a rising edge, held until ready is seen at a rising edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic ad, wd;
        ad = 1'b0;
        wd = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge clk_sys);
            if (!ad && awready) begin
                awvalid <= 1'b0;
                ad = 1'b1;
            end
            if (!wd && wready) begin
                wvalid <= 1'b0;
                wd = 1'b1;
            end
        end
        @(posedge clk_sys);
        while (!bvalid) @(posedge clk_sys);
        check(bresp, er);
    endtask

    // response taken at the edge where rvalid is seen high
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        @(posedge clk_sys);
        while (!arready) @(posedge clk_sys);
        arvalid <= 1'b0;
        @(posedge clk_sys);
        while (!rvalid) @(posedge clk_sys);
        check(rdata, ed);
        check(rresp, er);
    endtask

    // one access in every 8K block for each strobe kind, against the routing rules
    task automatic sweep(input logic [3:0] rt, input logic [2:0] es, input logic [1:0] rs,
                         input logic pg);
        int tgt;
        logic [2:0] a;
        axi_wr(`CDS_OFF_ROUTE, {28'h0, rt}, `CDS_RESP_OKAY);
        axi_wr(`CDS_OFF_EPROM, {29'h0, es}, `CDS_RESP_OKAY);
        axi_wr(`CDS_OFF_RAM, {27'h0, pg, 2'b00, rs}, `CDS_RESP_OKAY);
        axi_rd(`CDS_OFF_ROUTE, {28'h0, rt}, `CDS_RESP_OKAY);
        for (int b = 0; b < 8; b++) begin
            for (int k = 0; k < 3; k++) begin
                a = b[2:0];
                if (k == 2) tgt = 1;
                else if (k == 1) tgt = (a[2:1] == 2'b00) ? 1 :
                    (!a[2] ? (rt[1] ? 2 : 1) : (rt[3] ? 2 : 1));
                else if (a == 3'h0) tgt = 0;
                else if (a == 3'h1) tgt = 2;
                else tgt = !a[2] ? (rt[0] ? 1 : 2) : (rt[2] ? 1 : 2);
                cpu.start(k, {a, 5'h15});
                repeat (4) @(posedge clk_sys);
                check(mem_ctl, tgt == 1 ? {1'b0, k == 2, k != 2, 2'b11} :
                    (tgt == 2 ? 5'b11100 : 5'b11111));
                if (tgt == 1) check(ram_addr_hi, rs == 2'h0 ? 4'h0 :
                    (rs == 2'h1 ? {2'b00, a[1:0]} : {pg, a}));
                if (tgt == 2) check(eprom_addr_hi, a & es);
                cpu.stop();
                repeat (4) @(posedge clk_sys);
                check(mem_ctl, 5'b11111);
            end
        end
    endtask

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic test_reset();
        check(ics, 1'b1);
        check(mem_ctl, 5'b11111);
        axi_rd(`CDS_OFF_ROUTE, 32'h0, `CDS_RESP_OKAY);
        axi_rd(`CDS_OFF_EPROM, 32'h7, `CDS_RESP_OKAY);
        axi_rd(`CDS_OFF_RAM, 32'h2, `CDS_RESP_OKAY);
        axi_rd(`CDS_OFF_STATUS, 32'h1, `CDS_RESP_OKAY);
        $display("test_reset done");
    endtask

    task automatic test_default_map();
        sweep(4'h0, 3'h7, 2'h2, 1'b0);
        axi_rd(`CDS_OFF_STATUS, 32'h102, `CDS_RESP_OKAY);
        cpu.start(0, 8'h35);
        repeat (4) @(posedge clk_sys);
        cpu.stop();
        repeat (4) @(posedge clk_sys);
        axi_rd(`CDS_OFF_STATUS, 32'h114, `CDS_RESP_OKAY);
        axi_wr(`CDS_OFF_STATUS, 32'h100, `CDS_RESP_OKAY);
        axi_rd(`CDS_OFF_STATUS, 32'h014, `CDS_RESP_OKAY);
        $display("test_default_map done");
    endtask

    task automatic test_routing();
        for (int r = 1; r < 16; r++) sweep(r[3:0], 3'h7, 2'h2, 1'b1);
        $display("test_routing done");
    endtask

    task automatic test_sizes();
        logic [2:0] es [4] = '{3'h0, 3'h1, 3'h3, 3'h7};
        for (int i = 0; i < 4; i++) sweep(4'h5, es[i], i[1:0], i[0]);
        $display("test_sizes done");
    endtask

    task automatic test_unmapped();
        axi_wr(8'h10, 32'hf, `CDS_RESP_SLVERR);
        axi_rd(8'h10, 32'h0, `CDS_RESP_SLVERR);
        axi_rd(`CDS_OFF_ROUTE, 32'h5, `CDS_RESP_OKAY);
        $display("test_unmapped done");
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        sys_rst <= 1'b0;
        repeat (2) @(posedge clk_sys);
        test_reset();
        test_default_map();
        test_routing();
        test_sizes();
        test_unmapped();
        summarize();
    end
endmodule
